// *** design/wbr_pkg.sv ***
package wbr_pkg;
    // ------------------------------------------------------------
    // Command codes and read pointer positions
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_WRITE_CFG = 8'hd2;
    localparam logic [7:0] CMD_LINE_RESET = 8'hb4;
    localparam logic PTR_STATUS = 1'b0;
    localparam logic PTR_CONFIG = 1'b1;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CFG_APU = 0;
    localparam int CFG_SPU = 2;
    localparam int CFG_SPEED = 3;
    localparam int ST_BUSY = 0;
    localparam int ST_PRESENCE = 1;
    localparam int ST_SHORT = 2;
    localparam int ST_RESET = 4;
    localparam logic [3:0] CFG_RESET = 4'h0;
    localparam logic RST_FLAG_RESET = 1'b1;
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h18;

    // ------------------------------------------------------------
    // Line timing, in ns and in line clock cycles (rounded up)
    // ------------------------------------------------------------
    localparam int LINE_CLK_NS = 64;
    localparam int SYNC_LAT = 2;
    localparam int RSTL_STD_NS = 576;
    localparam int RSTH_STD_NS = 576;
    localparam int SI_STD_NS = 8;
    localparam int MSP_STD_NS = 64;
    localparam int RSTL_OD_NS = 64;
    localparam int RSTH_OD_NS = 192;
    localparam int SI_OD_NS = 1;
    localparam int MSP_OD_NS = 8;
    localparam int RND = LINE_CLK_NS - 1;
    localparam logic [15:0] RSTL_STD_CYC =
        16'((RSTL_STD_NS + RND) / LINE_CLK_NS);
    localparam logic [15:0] RSTH_STD_CYC =
        16'((RSTH_STD_NS + RND) / LINE_CLK_NS);
    localparam logic [15:0] SI_STD_CYC = 16'((SI_STD_NS + RND) / LINE_CLK_NS);
    localparam logic [15:0] MSP_STD_CYC = 16'((MSP_STD_NS + RND) / LINE_CLK_NS);
    localparam logic [15:0] RSTL_OD_CYC =
        16'((RSTL_OD_NS + RND) / LINE_CLK_NS);
    localparam logic [15:0] RSTH_OD_CYC =
        16'((RSTH_OD_NS + RND) / LINE_CLK_NS);
    localparam logic [15:0] SI_OD_CYC = 16'((SI_OD_NS + RND) / LINE_CLK_NS);
    localparam logic [15:0] MSP_OD_CYC = 16'((MSP_OD_NS + RND) / LINE_CLK_NS);
endpackage : wbr_pkg

// *** design/wbr_line_reset.sv ***
`timescale 1ns/100ps
`default_nettype none
module wbr_line_reset (
    input wire logic line_clk,
    input wire logic rst_n,
    input wire logic go_tgl,
    input wire logic speed_sel,
    input wire logic apu_sel,
    input wire logic spu_sel,
    input wire logic line_in,
    output logic done_tgl,
    output logic presence_seen,
    output logic short_seen,
    output logic line_out,
    output logic line_oe,
    output logic strong_pullup_on
);
    typedef enum logic [1:0] {W_IDLE, W_LOW, W_HIGH} wbr_wst_t;

    // ------------------------------------------------------------
    // Crossings from the system side and the pin
    // ------------------------------------------------------------
    logic [2:0] go_s_q;
    logic [2:0] cfg_s1_q, cfg_s2_q;
    logic line_s1_q, line_s2_q;
    always_ff @(posedge line_clk or negedge rst_n) begin
        if (!rst_n) begin
            go_s_q <= 3'h0;
            cfg_s1_q <= 3'h0;
            cfg_s2_q <= 3'h0;
            line_s1_q <= 1'b1;
            line_s2_q <= 1'b1;
        end else begin
            go_s_q <= {go_s_q[1:0], go_tgl};
            cfg_s1_q <= {speed_sel, apu_sel, spu_sel};
            cfg_s2_q <= cfg_s1_q;
            line_s1_q <= line_in;
            line_s2_q <= line_s1_q;
        end
    end
    logic go_evt;
    assign go_evt = go_s_q[2] ^ go_s_q[1];

    // ------------------------------------------------------------
    // Reset and presence-detect sequencer
    // ------------------------------------------------------------
    wbr_wst_t st_q, st_d;
    logic [15:0] cnt_q, cnt_d, low_cyc, high_cyc, si_idx, msp_idx;
    logic done_q, done_d, pres_q, pres_d, shrt_q, shrt_d;
    logic oe_q, oe_d, out_q, out_d, spu_q, spu_d;
    // Sample indices absorb the two-stage pin synchroniser delay
    always_comb begin
        low_cyc = cfg_s2_q[2] ? wbr_pkg::RSTL_OD_CYC : wbr_pkg::RSTL_STD_CYC;
        high_cyc = cfg_s2_q[2] ? wbr_pkg::RSTH_OD_CYC : wbr_pkg::RSTH_STD_CYC;
        si_idx = (cfg_s2_q[2] ? wbr_pkg::SI_OD_CYC : wbr_pkg::SI_STD_CYC)
            + 16'(wbr_pkg::SYNC_LAT - 1);
        msp_idx = (cfg_s2_q[2] ? wbr_pkg::MSP_OD_CYC : wbr_pkg::MSP_STD_CYC)
            + 16'(wbr_pkg::SYNC_LAT - 1);
        // Presence sample after the short check, else a pulse looks shorted
        if (msp_idx <= si_idx) begin
            msp_idx = si_idx + 16'h0001;
        end
        st_d = st_q;
        cnt_d = cnt_q + 16'h0001;
        done_d = done_q;
        pres_d = pres_q;
        shrt_d = shrt_q;
        oe_d = 1'b0;
        out_d = 1'b0;
        spu_d = spu_q;
        case (st_q)
            W_IDLE: begin
                cnt_d = 16'h0000;
                if (go_evt) begin
                    st_d = W_LOW;
                    oe_d = 1'b1;
                end
            end
            W_LOW: begin
                oe_d = 1'b1;
                if (cnt_q == low_cyc - 16'h0001) begin
                    st_d = W_HIGH;
                    cnt_d = 16'h0000;
                    oe_d = cfg_s2_q[1];
                    out_d = cfg_s2_q[1];
                    spu_d = cfg_s2_q[0];
                end
            end
            W_HIGH: begin
                if (cnt_q == si_idx) begin
                    shrt_d = ~line_s2_q;
                    if (!line_s2_q) begin
                        pres_d = 1'b0;
                    end
                end
                if (cnt_q == msp_idx) begin
                    pres_d = ~line_s2_q & ~shrt_d;
                end
                // At end of high time and at least one cycle past the sample, so results settle before done
                if (cnt_q >= high_cyc - 16'h0001 && cnt_q > msp_idx) begin
                    st_d = W_IDLE;
                    done_d = ~done_q;
                    spu_d = 1'b0;
                end
            end
            default: st_d = W_IDLE;
        endcase
    end
    always_ff @(posedge line_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= W_IDLE;
            cnt_q <= 16'h0000;
            done_q <= 1'b0;
            pres_q <= 1'b0;
            shrt_q <= 1'b0;
            oe_q <= 1'b0;
            out_q <= 1'b0;
            spu_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            done_q <= done_d;
            pres_q <= pres_d;
            shrt_q <= shrt_d;
            oe_q <= oe_d;
            out_q <= out_d;
            spu_q <= spu_d;
        end
    end
    assign done_tgl = done_q;
    assign presence_seen = pres_q;
    assign short_seen = shrt_q;
    assign line_oe = oe_q;
    assign line_out = out_q;
    assign strong_pullup_on = spu_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_low_start: assert property (
        @(posedge line_clk) disable iff (!rst_n)
        (st_q == W_IDLE && go_evt) |=> line_oe && !line_out
        ##1 (cfg_s2_q[2] || (line_oe && !line_out)))
        else $error("Line not pulled low after start");
    a_short_sample: assert property (
        @(posedge line_clk) disable iff (!rst_n)
        (st_q == W_HIGH && cnt_q == si_idx) |=> shrt_q == !$past(line_s2_q))
        else $error("Short flag does not follow line sample");
    a_pres_sample: assert property (
        @(posedge line_clk) disable iff (!rst_n)
        (st_q == W_HIGH && cnt_q == msp_idx)
        |=> pres_q == (!$past(line_s2_q) && !shrt_q))
        else $error("Presence flag does not follow line sample");
    a_short_masks: assert property (
        @(posedge line_clk) disable iff (!rst_n)
        shrt_q |-> !pres_q)
        else $error("Presence reported while short seen");
endmodule : wbr_line_reset
`default_nettype wire

// *** design/wbr_bridge.sv ***
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Config command code followed by one byte
// - Byte taken only if nibbles complement
// - Config reads give zero high nibble
// - Busy line: config code and byte refused
// - Accepted config applies at ack rise
// - Config write points reads at config
// - Reset command drives a reset cycle
// - Line sampled at short and presence instants
// - Busy line: reset code refused
// - Reset activity starts soon after ack
// - Busy held for low plus high time
// - Reset command points reads at status
// - Reset uses current speed and pullups
// - Presence flag follows the presence sample
// - Short flag follows the short sample
// - Short seen forces presence to zero
module wbr_bridge #(
    // Slave address value is arbitrary
    parameter logic [6:0] DEV_ADDR = wbr_pkg::DEV_ADDR_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic line_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic line_in,
    output logic line_out,
    output logic line_oe,
    output logic strong_pullup_on
);
    typedef enum logic [3:0] {
        I_IDLE, I_ADDR, I_AACK, I_CMD, I_CACK, I_PARM, I_PACK, I_RD, I_RACK
    } wbr_ist_t;

    // ------------------------------------------------------------
    // Pin and cross-domain synchronisers
    // ------------------------------------------------------------
    logic [2:0] scl_s_q, sda_s_q, done_s_q;
    logic [1:0] pres_s_q, shrt_s_q;
    logic done_tgl, line_pres, line_shrt;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
            done_s_q <= 3'h0;
            pres_s_q <= 2'h0;
            shrt_s_q <= 2'h0;
        end else begin
            scl_s_q <= {scl_s_q[1:0], scl_in};
            sda_s_q <= {sda_s_q[1:0], sda_in};
            done_s_q <= {done_s_q[1:0], done_tgl};
            pres_s_q <= {pres_s_q[0], line_pres};
            shrt_s_q <= {shrt_s_q[0], line_shrt};
        end
    end
    // Third stage only feeds the edge detectors
    logic scl_rise, scl_fall, start_det, stop_det, done_evt, sda_v;
    assign sda_v = sda_s_q[1];
    assign scl_rise = scl_s_q[1] & ~scl_s_q[2];
    assign scl_fall = ~scl_s_q[1] & scl_s_q[2];
    assign start_det = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2];
    assign stop_det = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2];
    // Results are stable long before the done toggle arrives
    assign done_evt = done_s_q[2] ^ done_s_q[1];

    // ------------------------------------------------------------
    // Register state and read data
    // ------------------------------------------------------------
    wbr_ist_t st_q, st_d;
    logic [3:0] bit_q, bit_d, cfg_q, cfg_d;
    logic [7:0] shift_q, shift_d, rd_byte;
    logic oe_q, oe_d, ack_q, ack_d, rw_q, rw_d, ptr_q, ptr_d;
    logic rflag_q, rflag_d, busy_q, busy_d, go_q, go_d;
    logic pres_q, pres_d, shrt_q, shrt_d, ack_v, sda_out_q;
    always_comb begin
        rd_byte = 8'h00;
        if (ptr_q == wbr_pkg::PTR_CONFIG) begin
            rd_byte[3:0] = cfg_q;
        end else begin
            rd_byte[wbr_pkg::ST_BUSY] = busy_q;
            rd_byte[wbr_pkg::ST_PRESENCE] = pres_q;
            rd_byte[wbr_pkg::ST_SHORT] = shrt_q;
            rd_byte[wbr_pkg::ST_RESET] = rflag_q;
        end
    end

    // ------------------------------------------------------------
    // Serial slave and command decoder
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        bit_d = bit_q;
        shift_d = shift_q;
        oe_d = oe_q;
        ack_d = ack_q;
        rw_d = rw_q;
        cfg_d = cfg_q;
        rflag_d = rflag_q;
        ptr_d = ptr_q;
        busy_d = busy_q;
        go_d = go_q;
        pres_d = pres_q;
        shrt_d = shrt_q;
        ack_v = 1'b0;
        // A busy set later in this block wins over the done clear
        if (done_evt) begin
            busy_d = 1'b0;
            pres_d = pres_s_q[1] & ~shrt_s_q[1];
            shrt_d = shrt_s_q[1];
        end
        if (start_det) begin
            st_d = I_ADDR;
            bit_d = 4'h0;
            oe_d = 1'b0;
        end else if (stop_det) begin
            st_d = I_IDLE;
            oe_d = 1'b0;
        end else begin
            case (st_q)
                I_IDLE: st_d = I_IDLE;
                I_ADDR, I_CMD, I_PARM: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], sda_v};
                        bit_d = bit_q + 4'h1;
                    end else if (scl_fall && bit_q == 4'h8) begin
                        bit_d = 4'h0;
                        case (st_q)
                            I_ADDR: begin
                                ack_v = shift_q[7:1] == DEV_ADDR;
                                rw_d = shift_q[0];
                                st_d = I_AACK;
                            end
                            I_CMD: begin
                                // Busy line makes both codes refused
                                ack_v = !busy_q &&
                                    (shift_q == wbr_pkg::CMD_WRITE_CFG ||
                                    shift_q == wbr_pkg::CMD_LINE_RESET);
                                st_d = I_CACK;
                            end
                            default: begin
                                ack_v = shift_q[7:4] == ~shift_q[3:0];
                                st_d = I_PACK;
                            end
                        endcase
                        ack_d = ack_v;
                        oe_d = ack_v;
                    end
                end
                I_AACK: begin
                    if (scl_fall) begin
                        oe_d = 1'b0;
                        if (!ack_q) begin
                            st_d = I_IDLE;
                        end else if (rw_q) begin
                            st_d = I_RD;
                            shift_d = rd_byte;
                            oe_d = ~rd_byte[7];
                        end else begin
                            st_d = I_CMD;
                        end
                    end
                end
                I_CACK: begin
                    if (scl_fall) begin
                        oe_d = 1'b0;
                        if (!ack_q) begin
                            st_d = I_IDLE;
                        end else if (shift_q == wbr_pkg::CMD_LINE_RESET) begin
                            go_d = ~go_q;
                            busy_d = 1'b1;
                            ptr_d = wbr_pkg::PTR_STATUS;
                            st_d = I_CMD;
                        end else begin
                            st_d = I_PARM;
                        end
                    end
                end
                I_PACK: begin
                    // Taken on the synced rise, just after the pin edge
                    if (scl_rise && ack_q) begin
                        cfg_d = shift_q[3:0];
                        rflag_d = 1'b0;
                        ptr_d = wbr_pkg::PTR_CONFIG;
                    end
                    if (scl_fall) begin
                        oe_d = 1'b0;
                        st_d = ack_q ? I_CMD : I_IDLE;
                    end
                end
                I_RD: begin
                    if (scl_fall) begin
                        if (bit_q == 4'h7) begin
                            oe_d = 1'b0;
                            bit_d = 4'h0;
                            st_d = I_RACK;
                        end else begin
                            bit_d = bit_q + 4'h1;
                            shift_d = {shift_q[6:0], 1'b0};
                            oe_d = ~shift_q[6];
                        end
                    end
                end
                I_RACK: begin
                    if (scl_rise) begin
                        ack_d = ~sda_v;
                    end
                    if (scl_fall) begin
                        if (ack_q) begin
                            st_d = I_RD;
                            shift_d = rd_byte;
                            oe_d = ~rd_byte[7];
                        end else begin
                            st_d = I_IDLE;
                        end
                    end
                end
                default: st_d = I_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= I_IDLE;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            oe_q <= 1'b0;
            ack_q <= 1'b0;
            rw_q <= 1'b0;
            cfg_q <= wbr_pkg::CFG_RESET;
            rflag_q <= wbr_pkg::RST_FLAG_RESET;
            ptr_q <= wbr_pkg::PTR_STATUS;
            busy_q <= 1'b0;
            go_q <= 1'b0;
            pres_q <= 1'b0;
            shrt_q <= 1'b0;
            sda_out_q <= 1'b0;
        end else begin
            st_q <= st_d;
            bit_q <= bit_d;
            shift_q <= shift_d;
            oe_q <= oe_d;
            ack_q <= ack_d;
            rw_q <= rw_d;
            cfg_q <= cfg_d;
            rflag_q <= rflag_d;
            ptr_q <= ptr_d;
            busy_q <= busy_d;
            go_q <= go_d;
            pres_q <= pres_d;
            shrt_q <= shrt_d;
            // Open-drain data pin only ever pulls low
            sda_out_q <= 1'b0;
        end
    end
    assign sda_oe = oe_q;
    assign sda_out = sda_out_q;

    // ------------------------------------------------------------
    // Line side on its own clock
    // ------------------------------------------------------------
    // Config cannot change while busy, so plain level sync is safe
    wbr_line_reset u_line (
        .line_clk(line_clk),
        .rst_n(rst_n),
        .go_tgl(go_q),
        .speed_sel(cfg_q[wbr_pkg::CFG_SPEED]),
        .apu_sel(cfg_q[wbr_pkg::CFG_APU]),
        .spu_sel(cfg_q[wbr_pkg::CFG_SPU]),
        .line_in(line_in),
        .done_tgl(done_tgl),
        .presence_seen(line_pres),
        .short_seen(line_shrt),
        .line_out(line_out),
        .line_oe(line_oe),
        .strong_pullup_on(strong_pullup_on)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic cfg_take;
    assign cfg_take = st_q == I_PACK && scl_rise && ack_q;

    a_cfg_hi_zero: assert property (
        ptr_q == wbr_pkg::PTR_CONFIG |-> rd_byte[7:4] == 4'h0)
        else $error("Config read high nibble not zero");
    a_cfg_update: assert property (
        cfg_take |=> cfg_q == $past(shift_q[3:0]) && !rflag_q)
        else $error("Config not stored at ack rise");
    a_cfg_reject: assert property (
        (st_q == I_PACK && !ack_q) |=> $stable(cfg_q))
        else $error("Rejected config changed register");
    a_cfg_nibbles: assert property (
        (st_q == I_PARM && st_d == I_PACK)
        |-> ack_d == (shift_q[7:4] == ~shift_q[3:0]))
        else $error("Config ack ignores nibble check");
    a_ptr_config: assert property (
        cfg_take |=> ptr_q == wbr_pkg::PTR_CONFIG)
        else $error("Pointer not at config after write");

    // ------------------------------------------------------------
    // Command and line result checks
    // ------------------------------------------------------------
    a_busy_nack: assert property (
        (st_q == I_CMD && st_d == I_CACK && busy_q) |=> !sda_oe [*2])
        else $error("Command acknowledged while busy");
    a_code_refused: assert property (
        (st_q == I_CACK && scl_fall && !ack_q)
        |=> st_q == I_IDLE && go_q == $past(go_q))
        else $error("Refused command was not ignored");
    a_reset_go: assert property (
        (st_q == I_CACK && scl_fall && ack_q
        && shift_q == wbr_pkg::CMD_LINE_RESET)
        |=> busy_q && go_q != $past(go_q)
        && ptr_q == wbr_pkg::PTR_STATUS)
        else $error("Reset command did not start or point status");
    a_busy_hold: assert property (
        (busy_q && !done_evt) |=> busy_q)
        else $error("Busy dropped before cycle end");
    a_busy_done: assert property (done_evt |=> !busy_q)
        else $error("Busy not cleared at cycle end");
    a_short_update: assert property (
        done_evt |=> shrt_q == $past(shrt_s_q[1]))
        else $error("Short flag not taken at cycle end");
    a_no_pres_short: assert property (shrt_q |-> !pres_q)
        else $error("Presence shown with short");

    c_cfg_ok: cover property (cfg_take);
    c_cfg_bad: cover property (st_q == I_PACK && scl_fall && !ack_q);
    c_reset_go: cover property ($rose(busy_q));
    c_presence: cover property ($rose(pres_q));
    c_short: cover property ($rose(shrt_q));
endmodule : wbr_bridge
`default_nettype wire

// *** tb/wbr_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module wbr_host_model (
    input wire logic sys_clk,
    output logic scl,
    output logic sda_drv,
    input wire logic sda
);
    // ----------------------------------------------------------
    // Serial host, moves only on falling sys_clk edges
    // ----------------------------------------------------------
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : hold
    // Gap after scl fall keeps a data change from passing for a stop
    task automatic bit_io(input logic b, output logic r);
        sda_drv = b;
        hold(10);
        scl = 1'b1;
        hold(5);
        r = sda;
        hold(5);
        scl = 1'b0;
        hold(2);
    endtask : bit_io
    task automatic start();
        sda_drv = 1'b1;
        scl = 1'b1;
        hold(10);
        sda_drv = 1'b0;
        hold(10);
        scl = 1'b0;
        hold(2);
    endtask : start
    task automatic stop();
        sda_drv = 1'b0;
        hold(10);
        scl = 1'b1;
        hold(10);
        sda_drv = 1'b1;
        hold(10);
    endtask : stop
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask : wr_byte
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(last, r);
    endtask : rd_byte
endmodule : wbr_host_model
`default_nettype wire

// *** tb/tb_wire_bridge_config_and_bus_reset.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_wire_bridge_config_and_bus_reset;
    localparam logic [6:0] ADDR = 7'h18;
    localparam logic [7:0] CFG [3] = '{8'he1, 8'h78, 8'hf0};
    localparam logic [7:0] NXT [3] = '{8'hb4, 8'h00, 8'hd2};
    localparam logic SHORT [3] = '{1'b0, 1'b0, 1'b1};
    localparam logic [7:0] LOW [3] = '{8'h09, 8'h01, 8'h09};
    localparam logic [7:0] KICK [3] = '{8'h01, 8'h00, 8'h00};
    localparam logic [7:0] ST [3] = '{8'h02, 8'h00, 8'h04};
    localparam logic PRES [3] = '{1'b1, 1'b0, 1'b1};
    logic sys_clk, line_clk, rst_n, short_on, scl, sda_drv, ack;
    logic sda_out, sda_oe, line_out, line_oe, spu_on, pres_on, pull;
    logic [7:0] rd;
    wire logic sda_w;
    wire logic line_w;
    int error_cnt, check_count, cyc, low_cnt, kick_cnt, rel_cnt, spu_cnt;
    // ----------------------------------------------------------
    // Wires with pull-ups; a short holds the line low
    // ----------------------------------------------------------
    assign sda_w = sda_drv & ~(sda_oe & ~sda_out);
    assign line_w = (line_oe ? line_out : 1'b1) & ~short_on & ~pull;
    // Slave answers a reset low from the second cycle after release
    assign pull = pres_on && rel_cnt >= 2 && rel_cnt <= 5;
    always @(negedge line_clk) begin
        if (line_oe === 1'b1 && line_out === 1'b0) rel_cnt = 0;
        else if (rel_cnt < 15) rel_cnt++;
    end
    wbr_bridge #(.DEV_ADDR(ADDR)) wbr_bridge_i (.sys_clk(sys_clk),
        .rst_n(rst_n), .line_clk(line_clk), .scl_in(scl),
        .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
        .line_in(line_w), .line_out(line_out), .line_oe(line_oe),
        .strong_pullup_on(spu_on));
    wbr_host_model wbr_host_model_i (.sys_clk(sys_clk), .scl(scl),
        .sda_drv(sda_drv), .sda(sda_w));
    always #2 sys_clk = ~sys_clk;
    always @(posedge line_clk) begin
        if (line_oe === 1'b1 && line_out === 1'b0) low_cnt++;
        if (line_oe === 1'b1 && line_out === 1'b1) kick_cnt++;
        if (spu_on === 1'b1) spu_cnt++;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 80000) begin
            error_cnt++;
            end_of_test();
        end
    end
    // ----------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic read_reg(output logic [7:0] d);
        wbr_host_model_i.start();
        wbr_host_model_i.wr_byte({ADDR, 1'b1}, ack);
        wbr_host_model_i.rd_byte(1'b1, d);
        wbr_host_model_i.stop();
    endtask : read_reg
    // Both bytes always sent; after a refusal the second must go unheard
    task automatic write_seq(input logic [7:0] c0, input logic [7:0] c1,
                             input logic [1:0] exp);
        wbr_host_model_i.start();
        wbr_host_model_i.wr_byte({ADDR, 1'b0}, ack);
        check({7'h0, ack}, 8'h01);
        wbr_host_model_i.wr_byte(c0, ack);
        check({7'h0, ack}, {7'h0, exp[1]});
        wbr_host_model_i.wr_byte(c1, ack);
        check({7'h0, ack}, {7'h0, exp[0]});
        wbr_host_model_i.stop();
    endtask : write_seq
    task automatic poll_idle();
        int n;
        n = 0;
        read_reg(rd);
        while (rd[0] !== 1'b0 && n < 40) begin
            read_reg(rd);
            n++;
        end
    endtask : poll_idle
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test
    // ----------------------------------------------------------
    // Sequence; no run enables the strong pullup during a reset
    // ----------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        line_clk = 1'b0;
        rst_n = 1'b0;
        short_on = 1'b0;
        pres_on = 1'b0;
        {error_cnt, check_count, cyc, low_cnt, kick_cnt} = '0;
        repeat (3) @(negedge line_clk);
        @(negedge sys_clk);
        rst_n = 1'b1;
        wbr_host_model_i.hold(3);
        read_reg(rd);
        check(rd, 8'h10);
        write_seq(wbr_pkg::CMD_WRITE_CFG, 8'h5b, 2'b10);
        read_reg(rd);
        check(rd, 8'h10);
        write_seq(wbr_pkg::CMD_WRITE_CFG, 8'h5a, 2'b11);
        read_reg(rd);
        check(rd, 8'h0a);
        for (int i = 0; i < 3; i++) begin
            low_cnt = 0;
            write_seq(wbr_pkg::CMD_WRITE_CFG, CFG[i], 2'b11);
            read_reg(rd);
            check(rd, {4'h0, CFG[i][3:0]});
            check(8'(low_cnt), 8'h00);
            short_on = SHORT[i];
            pres_on = PRES[i];
            low_cnt = 0;
            kick_cnt = 0;
            write_seq(wbr_pkg::CMD_LINE_RESET,
                NXT[i], 2'b10);
            poll_idle();
            check(rd, ST[i]);
            check(8'(low_cnt), LOW[i]);
            check(8'(kick_cnt), KICK[i]);
            check(8'(spu_cnt), 8'h00);
        end
        end_of_test();
    end
    // Link clock offset so its edges never line up with sys_clk
    initial begin
        #7;
        forever #32 line_clk = ~line_clk;
    end
endmodule : tb_wire_bridge_config_and_bus_reset
`default_nettype wire
